// >>> ancillary_memory.v
// Small dual-port memory holding extracted ancillary packet words.
// Assumes one clock; write port fed by the packet extractor, read data registered.
`timescale 1ns/1ps
module ancillary_memory #(
    parameter DEPTH  = 256,
    parameter ADDR_W = 8,
    parameter DATA_W = 32
) (
    input  wire              clk,
    input  wire              wr_en,
    input  wire [ADDR_W-1:0] wr_addr,
    input  wire [DATA_W-1:0] wr_data,
    input  wire              rd_en,
    input  wire [ADDR_W-1:0] rd_addr,
    output reg  [DATA_W-1:0] rd_data
);

    reg [DATA_W-1:0] store [0:DEPTH-1];

    // No reset on the array so that it maps onto block memory.
    always @(posedge clk) begin
        if (wr_en) begin
            store[wr_addr] <= wr_data;
        end
        if (rd_en) begin
            rd_data <= store[rd_addr];
        end
    end

endmodule

// >>> host_port_model.sv
// Host processor model driving the register port with single-cycle strobes.
// Assumes read data stand in the cycle after the strobe and never stall.
`timescale 1ns/1ps
module host_port_model #(
    parameter ADDR_W = 10
) (
    input  wire               clk,
    input  wire  [31:0]       read_data,
    output logic [ADDR_W-1:0] address,
    output logic [31:0]       write_data,
    output logic              write_strobe,
    output logic              read_strobe
);
    initial begin
        address = '0;
        write_data = 32'h0000_0000;
        write_strobe = 1'b0;
        read_strobe = 1'b0;
    end
    // Released lines show the inverse so a stale value is never mistaken for a live one.
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clk);
        address <= a;
        write_data <= d;
        write_strobe <= 1'b1;
        @(posedge clk);
        write_strobe <= 1'b0;
        address <= ~a;
        write_data <= ~d;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
        @(posedge clk);
        address <= a;
        read_strobe <= 1'b1;
        @(posedge clk);
        read_strobe <= 1'b0;
        address <= ~a;
        @(negedge clk);
        d = read_data;
    endtask
endmodule

// >>> video_input_status_registers.v
// Status, interrupt, measurement and ancillary window registers of a video input core.
// Assumes capture logic on clk supplies measurements and event pulses; video pins are asynchronous.
//
// What this block does
// - Status bit 13 reads one while the picture is padded; present only if padding configured.
// - Status bit 14 sets on any picture drop, cleared by writing one.
// - Status bits 21-15 count drops while sticky set; cleared with the sticky flag.
// - Drop flag and count exist only with padding or overflow handling configured.
// - Interrupt register bit 1 sets when the status-update interrupt triggers.
// - Interrupt register bit 2 sets when the end-of-field interrupt triggers.
// - Interrupt bits stay set until the host writes one to them.
// - Offset 3 reads the input FIFO fill level in words.
// - Offset 4 reads measured active samples per line.
// - Offsets 5 and 6 read active line counts of both fields.
// - Offset 7 reads measured total samples per line.
// - Offsets 8 and 9 read total line counts of both fields.
// - Offset 10 reads the current video standard input.
// - Offsets 11 to 13 are reserved and carry no function.
// - Offset 14 captures colour encoding in bits 7-0, bit width in 15-8.
// - Ancillary packets are readable from offset 15 over the memory depth.
// - Status bit 9 sets on FIFO overflow, cleared by writing one.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`include "video_input_status_regs.vh"
module video_input_status_registers #(
    parameter PADDING_EN  = 1,
    parameter OVERFLOW_EN = 1,
    parameter CLIPPING_EN = 1,
    parameter ANC_DEPTH   = 256,
    parameter ANC_ADDR_W  = 8,
    parameter ADDR_W      = 10,
    parameter STD_W       = 3,
    parameter COUNT_W     = 16
) (
    input  wire                  clk,
    input  wire                  reset_n,
    input  wire [ADDR_W-1:0]     address,
    input  wire [31:0]           write_data,
    input  wire                  write_strobe,
    input  wire                  read_strobe,
    output wire [31:0]           read_data,
    output wire                  irq,
    output wire                  go,
    input  wire                  producing,
    input  wire                  interlaced,
    input  wire                  stable,
    input  wire                  resolution_valid,
    input  wire                  clipping,
    input  wire                  padding,
    input  wire                  fifo_overflow_event,
    input  wire                  picture_drop_event,
    input  wire                  status_update_event,
    input  wire                  end_of_field_event,
    input  wire [COUNT_W-1:0]    fifo_fill_level,
    input  wire [COUNT_W-1:0]    active_samples_per_line,
    input  wire [COUNT_W-1:0]    first_field_active_lines,
    input  wire [COUNT_W-1:0]    second_field_active_lines,
    input  wire [COUNT_W-1:0]    total_samples_per_line,
    input  wire [COUNT_W-1:0]    first_field_total_lines,
    input  wire [COUNT_W-1:0]    second_field_total_lines,
    input  wire                  vid_locked,
    input  wire [STD_W-1:0]      vid_std,
    input  wire [7:0]            vid_colour_encoding,
    input  wire [7:0]            vid_bit_width,
    input  wire                  anc_wr_en,
    input  wire [ANC_ADDR_W-1:0] anc_wr_addr,
    input  wire [31:0]           anc_wr_data
);

    localparam DROP_EN = (PADDING_EN != 0) || (OVERFLOW_EN != 0);
    localparam SYNC_W  = STD_W + 8 + 8 + 1;

    reg  [`CTRL_WIDTH-1:0] control;
    reg                    overflow_sticky;
    reg                    drop_sticky;
    reg  [`DROP_COUNT_WIDTH-1:0] drop_count;
    reg  [2:1]             pending;
    reg  [31:0]            reg_read;
    reg                    anc_selected;
    reg  [31:0]            next_reg_read;

    // Pins from the video side: three stages, a change is taken once stages two and three agree.
    wire [SYNC_W-1:0]      pin_raw;
    reg  [SYNC_W-1:0]      sync1;
    reg  [SYNC_W-1:0]      sync2;
    reg  [SYNC_W-1:0]      sync3;
    reg  [SYNC_W-1:0]      pin_held;

    assign pin_raw = {vid_locked, vid_bit_width, vid_colour_encoding, vid_std};

    genvar i;
    generate
        for (i = 0; i < SYNC_W; i = i + 1) begin : pin_sync
            always @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    sync1[i]    <= 1'b0;
                    sync2[i]    <= 1'b0;
                    sync3[i]    <= 1'b0;
                    pin_held[i] <= 1'b0;
                end else begin
                    sync1[i] <= pin_raw[i];
                    sync2[i] <= sync1[i];
                    sync3[i] <= sync2[i];
                    if (sync2[i] == sync3[i]) begin
                        pin_held[i] <= sync3[i];
                    end
                end
            end
        end
    endgenerate

    wire [STD_W-1:0] std_now      = pin_held[STD_W-1:0];
    wire [7:0]       encoding_now = pin_held[STD_W+7:STD_W];
    wire [7:0]       width_now    = pin_held[STD_W+15:STD_W+8];
    wire             locked_now   = pin_held[SYNC_W-1];

    wire wr_control = write_strobe && (address == `OFS_CONTROL);
    wire wr_status  = write_strobe && (address == `OFS_INPUT_STATUS);
    wire wr_pending = write_strobe && (address == `OFS_INTERRUPT_PENDING);

    wire clear_overflow = wr_status && write_data[`ST_OVERFLOW_BIT];
    wire clear_drop     = wr_status && write_data[`ST_DROP_STICKY_BIT];

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            control <= `CTRL_RESET;
        end else if (wr_control) begin
            control <= write_data[`CTRL_WIDTH-1:0];
        end
    end

    assign go = control[`CTRL_GO_BIT];

    // A new overflow in the clearing cycle keeps the flag set.
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            overflow_sticky <= 1'b0;
        end else if (fifo_overflow_event) begin
            overflow_sticky <= 1'b1;
        end else if (clear_overflow) begin
            overflow_sticky <= 1'b0;
        end
    end

    // The count restarts from the drop that coincides with a clear, so that drop is not lost.
    // It saturates rather than wrapping, so software never sees a small count after many drops.
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            drop_sticky <= 1'b0;
            drop_count  <= {`DROP_COUNT_WIDTH{1'b0}};
        end else if (DROP_EN) begin
            if (clear_drop) begin
                drop_sticky <= picture_drop_event;
                drop_count  <= picture_drop_event ? {{(`DROP_COUNT_WIDTH-1){1'b0}}, 1'b1}
                                                  : {`DROP_COUNT_WIDTH{1'b0}};
            end else if (picture_drop_event) begin
                drop_sticky <= 1'b1;
                if (drop_count != `DROP_COUNT_MAX) begin
                    drop_count <= drop_count + {{(`DROP_COUNT_WIDTH-1){1'b0}}, 1'b1};
                end
            end
        end
    end

    // Set wins over a write-one clear in the same cycle.
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pending <= `IRQ_PENDING_RESET;
        end else begin
            pending[`IRQ_STATUS_UPDATE_BIT] <= status_update_event ||
                (pending[`IRQ_STATUS_UPDATE_BIT] &&
                 !(wr_pending && write_data[`IRQ_STATUS_UPDATE_BIT]));
            pending[`IRQ_END_OF_FIELD_BIT] <= end_of_field_event ||
                (pending[`IRQ_END_OF_FIELD_BIT] &&
                 !(wr_pending && write_data[`IRQ_END_OF_FIELD_BIT]));
        end
    end

    // Control bits 1 and 2 act as the mask of the pending register.
    assign irq = |(pending & control[2:1]);

    wire [31:0] status_word;
    assign status_word[`ST_PRODUCING_BIT]                    = producing;
    assign status_word[6:1]                                  = 6'h00;
    assign status_word[`ST_INTERLACED_BIT]                   = interlaced;
    assign status_word[`ST_STABLE_BIT]                       = stable;
    assign status_word[`ST_OVERFLOW_BIT]                     = overflow_sticky;
    assign status_word[`ST_RESOLUTION_BIT]                   = resolution_valid;
    assign status_word[`ST_LOCKED_BIT]                       = locked_now;
    assign status_word[`ST_CLIPPING_BIT]                     = (CLIPPING_EN != 0) && clipping;
    assign status_word[`ST_PADDING_BIT]                      = (PADDING_EN != 0) && padding;
    assign status_word[`ST_DROP_STICKY_BIT]                  = drop_sticky;
    assign status_word[`ST_DROP_COUNT_MSB:`ST_DROP_COUNT_LSB] = drop_count;
    assign status_word[31:22]                                = 10'h000;

    wire [31-COUNT_W:0] count_pad = {(32-COUNT_W){1'b0}};

    always @* begin
        next_reg_read = 32'h0000_0000;
        case (address)
            `OFS_CONTROL:             next_reg_read = {{(32-`CTRL_WIDTH){1'b0}}, control};
            `OFS_INPUT_STATUS:        next_reg_read = status_word;
            `OFS_INTERRUPT_PENDING:   next_reg_read = {29'h0000_0000, pending, 1'b0};
            `OFS_FIFO_FILL_LEVEL:     next_reg_read = {count_pad, fifo_fill_level};
            `OFS_ACTIVE_SAMPLES:      next_reg_read = {count_pad, active_samples_per_line};
            `OFS_FIRST_FIELD_ACTIVE:  next_reg_read = {count_pad, first_field_active_lines};
            `OFS_SECOND_FIELD_ACTIVE: next_reg_read = {count_pad, second_field_active_lines};
            `OFS_TOTAL_SAMPLES:       next_reg_read = {count_pad, total_samples_per_line};
            `OFS_FIRST_FIELD_TOTAL:   next_reg_read = {count_pad, first_field_total_lines};
            `OFS_SECOND_FIELD_TOTAL:  next_reg_read = {count_pad, second_field_total_lines};
            `OFS_VIDEO_STANDARD:      next_reg_read = {{(32-STD_W){1'b0}}, std_now};
            `OFS_COLOUR_FORMAT:       next_reg_read = {16'h0000, width_now, encoding_now};
            default:                  next_reg_read = 32'h0000_0000;
        endcase
    end

    wire anc_hit = (address >= `OFS_ANCILLARY_WINDOW) &&
                   (address < `OFS_ANCILLARY_WINDOW + ANC_DEPTH);
    wire [ADDR_W-1:0] anc_offset = address - `OFS_ANCILLARY_WINDOW;
    wire [31:0] anc_read;

    ancillary_memory #(
        .DEPTH  (ANC_DEPTH),
        .ADDR_W (ANC_ADDR_W),
        .DATA_W (32)
    ) anc_store (
        .clk     (clk),
        .wr_en   (anc_wr_en),
        .wr_addr (anc_wr_addr),
        .wr_data (anc_wr_data),
        .rd_en   (read_strobe && anc_hit),
        .rd_addr (anc_offset[ANC_ADDR_W-1:0]),
        .rd_data (anc_read)
    );

    // Read data are driven only in the cycle after the strobe and read as zero otherwise.
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_read     <= 32'h0000_0000;
            anc_selected <= 1'b0;
        end else begin
            reg_read     <= (read_strobe && !anc_hit) ? next_reg_read : 32'h0000_0000;
            anc_selected <= read_strobe && anc_hit;
        end
    end

    assign read_data = anc_selected ? anc_read : reg_read;

endmodule

// >>> video_input_status_registers_bench.sv
// Self-checking bench for the video input status register block.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module video_input_status_registers_bench;
    logic        clk, reset_n, write_strobe, read_strobe, irq, go;
    logic [9:0]  address;
    logic [31:0] write_data, read_data, anc_wr_data;
    logic        producing, interlaced, stable, resolution_valid, clipping, padding, vid_locked;
    logic        fifo_overflow_event, picture_drop_event, status_update_event, end_of_field_event, anc_wr_en;
    logic [7:0]  vid_colour_encoding, vid_bit_width, anc_wr_addr;
    logic [2:0]  vid_std;
    logic [15:0] fifo_fill_level, active_samples_per_line;
    int          num_errors = 0;
    int          compares = 0;
    typedef struct {logic [9:0] a; logic [31:0] v;} row_t;
    row_t        rows [14];
    video_input_status_registers dut_u (.clk(clk), .reset_n(reset_n), .address(address),
        .write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
        .irq(irq), .go(go), .producing(producing), .interlaced(interlaced), .stable(stable),
        .resolution_valid(resolution_valid), .clipping(clipping), .padding(padding),
        .fifo_overflow_event(fifo_overflow_event), .picture_drop_event(picture_drop_event),
        .status_update_event(status_update_event), .end_of_field_event(end_of_field_event),
        .fifo_fill_level(fifo_fill_level), .active_samples_per_line(active_samples_per_line),
        .first_field_active_lines(16'h021c),
        .second_field_active_lines(16'h021d), .total_samples_per_line(16'h0898),
        .first_field_total_lines(16'h0232), .second_field_total_lines(16'h0233), .vid_locked(vid_locked),
        .vid_std(vid_std), .vid_colour_encoding(vid_colour_encoding), .vid_bit_width(vid_bit_width),
        .anc_wr_en(anc_wr_en), .anc_wr_addr(anc_wr_addr), .anc_wr_data(anc_wr_data));
    host_port_model host_u (.clk(clk), .read_data(read_data), .address(address), .write_data(write_data),
        .write_strobe(write_strobe), .read_strobe(read_strobe));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rd_chk(input logic [9:0] a, input logic [31:0] e);
        logic [31:0] d;
        host_u.rd(a, d);
        chk(d, e);
    endtask
    task automatic tally_and_finish;
        $display("compares=%0d num_errors=%0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        repeat (3000) @(posedge clk);
        num_errors++;
        tally_and_finish;
    end
    initial begin
        rows = '{'{10'h001, 32'h0000_3d81}, '{10'h003, 32'h0000_0123}, '{10'h004, 32'h0000_0780},
            '{10'h005, 32'h0000_021c}, '{10'h006, 32'h0000_021d}, '{10'h007, 32'h0000_0898},
            '{10'h008, 32'h0000_0232}, '{10'h009, 32'h0000_0233}, '{10'h00a, 32'h0000_0005},
            '{10'h00b, 32'h0000_0000}, '{10'h00c, 32'h0000_0000}, '{10'h00d, 32'h0000_0000},
            '{10'h00e, 32'h0000_0a02}, '{10'h10f, 32'h0000_0000}};
        {producing, interlaced, stable, resolution_valid, clipping, padding, vid_locked} = 7'h7f;
        {fifo_overflow_event, picture_drop_event, status_update_event, end_of_field_event, anc_wr_en} = 5'h00;
        {vid_std, vid_colour_encoding, vid_bit_width} = {3'h5, 8'h02, 8'h0a};
        {anc_wr_addr, anc_wr_data} = 40'h00_0000_0000;
        {fifo_fill_level, active_samples_per_line} = {16'h0123, 16'h0780};
        reset_n = 1'b0;
        repeat (6) @(posedge clk);
        chk(read_data, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0000_0000);
        reset_n <= 1'b1;
        $display("reset test done");
        repeat (8) @(posedge clk);
        host_u.wr(10'h003, 32'hffff_ffff);
        foreach (rows[i]) rd_chk(rows[i].a, rows[i].v);
        $display("register table done");
        host_u.wr(10'h000, 32'h0000_0006);
        @(posedge clk) status_update_event <= 1'b1;
        @(posedge clk) status_update_event <= 1'b0;
        #1 chk({31'h0, irq}, 32'h0000_0001);
        rd_chk(10'h002, 32'h0000_0002);
        host_u.wr(10'h002, 32'h0000_0002);
        #1 chk({31'h0, irq}, 32'h0000_0000);
        host_u.wr(10'h000, 32'h0000_0004);
        @(posedge clk) status_update_event <= 1'b1;
        @(posedge clk) status_update_event <= 1'b0;
        #1 chk({31'h0, irq}, 32'h0000_0000);
        rd_chk(10'h002, 32'h0000_0002);
        @(posedge clk) end_of_field_event <= 1'b1;
        @(posedge clk) end_of_field_event <= 1'b0;
        #1 chk({31'h0, irq}, 32'h0000_0001);
        rd_chk(10'h002, 32'h0000_0006);
        host_u.wr(10'h002, 32'h0000_0006);
        #1 chk({31'h0, irq}, 32'h0000_0000);
        rd_chk(10'h002, 32'h0000_0000);
        host_u.wr(10'h000, 32'h0000_0001);
        #1 chk({31'h0, go}, 32'h0000_0001);
        $display("interrupt test done");
        @(posedge clk) {picture_drop_event, fifo_overflow_event} <= 2'b11;
        @(posedge clk) fifo_overflow_event <= 1'b0;
        repeat (2) @(posedge clk);
        picture_drop_event <= 1'b0;
        rd_chk(10'h001, 32'h0001_ff81);
        @(posedge clk) picture_drop_event <= 1'b1;
        repeat (130) @(posedge clk);
        picture_drop_event <= 1'b0;
        rd_chk(10'h001, 32'h003f_ff81);
        host_u.wr(10'h001, 32'h0000_4200);
        padding <= 1'b0;
        rd_chk(10'h001, 32'h0000_1d81);
        $display("drop test done");
        @(posedge clk) {anc_wr_en, anc_wr_addr, anc_wr_data} <= {1'b1, 8'h00, 32'hcafe_0001};
        @(posedge clk) {anc_wr_addr, anc_wr_data} <= {8'hff, 32'h1234_5678};
        @(posedge clk) anc_wr_en <= 1'b0;
        rd_chk(10'h00f, 32'hcafe_0001);
        rd_chk(10'h10e, 32'h1234_5678);
        $display("ancillary test done");
        // Pins need four edges through the synchroniser before the register shows them.
        @(posedge clk) {fifo_fill_level, active_samples_per_line, vid_std} <= {16'h0456, 16'h0a00, 3'h2};
        repeat (4) @(posedge clk);
        rd_chk(10'h003, 32'h0000_0456);
        rd_chk(10'h004, 32'h0000_0a00);
        rd_chk(10'h00a, 32'h0000_0002);
        $display("measurement change test done");
        tally_and_finish;
    end
endmodule

// >>> video_input_status_registers_props.sv
// Concurrent checks on the ports of the video input status register block.
// Assumes single-cycle strobes that are never raised together.
`timescale 1ns/1ps
`include "video_input_status_regs.vh"
module vis_props #(
    parameter ADDR_W  = 10,
    parameter COUNT_W = 16
) (
    input wire               clk,
    input wire               reset_n,
    input wire [ADDR_W-1:0]  address,
    input wire               write_strobe,
    input wire               read_strobe,
    input wire [31:0]        read_data,
    input wire               irq,
    input wire               picture_drop_event,
    input wire               status_update_event,
    input wire               end_of_field_event,
    input wire [COUNT_W-1:0] fifo_fill_level,
    input wire [COUNT_W-1:0] active_samples_per_line,
    input wire [COUNT_W-1:0] total_samples_per_line,
    input wire [7:0]         vid_colour_encoding,
    input wire [7:0]         vid_bit_width
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_fill;
        read_strobe && address == `OFS_FIFO_FILL_LEVEL |=> read_data == 32'($past(fifo_fill_level));
    endproperty
    a_fill: assert property (p_fill) else $error("fill level read wrong");
    property p_active;
        read_strobe && address == `OFS_ACTIVE_SAMPLES |=> read_data == 32'($past(active_samples_per_line));
    endproperty
    a_active: assert property (p_active) else $error("active samples read wrong");
    property p_total;
        read_strobe && address == `OFS_TOTAL_SAMPLES |=> read_data == 32'($past(total_samples_per_line));
    endproperty
    a_total: assert property (p_total) else $error("total samples read wrong");
    property p_reserved;
        read_strobe && address >= `OFS_RESERVED_FIRST && address <= `OFS_RESERVED_LAST |=> read_data == 32'h0000_0000;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved word not zero");
    // The pins pass a synchroniser, so only a read after a quiet spell is judged.
    property p_colour;
        $stable({vid_bit_width, vid_colour_encoding})[*6] ##0 (read_strobe && address == `OFS_COLOUR_FORMAT)
            |=> read_data == {16'h0000, $past(vid_bit_width), $past(vid_colour_encoding)};
    endproperty
    a_colour: assert property (p_colour) else $error("colour capture wrong");
    property p_drop;
        picture_drop_event ##1 !write_strobe ##1 (read_strobe && address == `OFS_INPUT_STATUS) |=> read_data[14];
    endproperty
    a_drop: assert property (p_drop) else $error("drop flag not set");
    property p_upd;
        status_update_event ##1 !write_strobe ##1 (read_strobe && address == `OFS_INTERRUPT_PENDING) |=> read_data[1];
    endproperty
    a_upd: assert property (p_upd) else $error("update pending not set");
    property p_eof;
        end_of_field_event ##1 !write_strobe ##1 (read_strobe && address == `OFS_INTERRUPT_PENDING) |=> read_data[2];
    endproperty
    a_eof: assert property (p_eof) else $error("field pending not set");
    property p_irq_rise;
        $rose(irq) |-> $past(status_update_event || end_of_field_event || (write_strobe && address == `OFS_CONTROL));
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("interrupt rose without cause");
    property p_irq_fall;
        $fell(irq) |-> $past(write_strobe && (address == `OFS_CONTROL || address == `OFS_INTERRUPT_PENDING));
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("interrupt fell without a write");
    c_irq: cover property ($rose(irq));
    c_drop: cover property (picture_drop_event [*8]);
    c_anc: cover property (read_strobe && address == 10'h10e);
endmodule
bind video_input_status_registers vis_props #(.ADDR_W(ADDR_W), .COUNT_W(COUNT_W)) chk_u (
    .clk(clk), .reset_n(reset_n), .address(address), .write_strobe(write_strobe),
    .read_strobe(read_strobe), .read_data(read_data), .irq(irq), .picture_drop_event(picture_drop_event),
    .status_update_event(status_update_event), .end_of_field_event(end_of_field_event),
    .fifo_fill_level(fifo_fill_level), .active_samples_per_line(active_samples_per_line),
    .total_samples_per_line(total_samples_per_line), .vid_colour_encoding(vid_colour_encoding),
    .vid_bit_width(vid_bit_width));

// >>> video_input_status_regs.vh
// Register map, field positions and reset values of the video input status block.
// Assumes a word-addressed register port; offsets below are word indices.
`ifndef VIDEO_INPUT_STATUS_REGS_VH
`define VIDEO_INPUT_STATUS_REGS_VH

`define OFS_CONTROL             8'h00
`define OFS_INPUT_STATUS        8'h01
`define OFS_INTERRUPT_PENDING   8'h02
`define OFS_FIFO_FILL_LEVEL     8'h03
`define OFS_ACTIVE_SAMPLES      8'h04
`define OFS_FIRST_FIELD_ACTIVE  8'h05
`define OFS_SECOND_FIELD_ACTIVE 8'h06
`define OFS_TOTAL_SAMPLES       8'h07
`define OFS_FIRST_FIELD_TOTAL   8'h08
`define OFS_SECOND_FIELD_TOTAL  8'h09
`define OFS_VIDEO_STANDARD      8'h0a
`define OFS_RESERVED_FIRST      8'h0b
`define OFS_RESERVED_LAST       8'h0d
`define OFS_COLOUR_FORMAT       8'h0e
`define OFS_ANCILLARY_WINDOW    8'h0f

`define CTRL_GO_BIT             0
`define CTRL_STATUS_IRQ_EN_BIT  1
`define CTRL_FIELD_IRQ_EN_BIT   2
`define CTRL_WIDTH              4
`define CTRL_RESET              4'h0

`define ST_PRODUCING_BIT        0
`define ST_INTERLACED_BIT       7
`define ST_STABLE_BIT           8
`define ST_OVERFLOW_BIT         9
`define ST_RESOLUTION_BIT       10
`define ST_LOCKED_BIT           11
`define ST_CLIPPING_BIT         12
`define ST_PADDING_BIT          13
`define ST_DROP_STICKY_BIT      14
`define ST_DROP_COUNT_LSB       15
`define ST_DROP_COUNT_MSB       21
`define DROP_COUNT_WIDTH        7
`define DROP_COUNT_MAX          7'h7f

`define IRQ_STATUS_UPDATE_BIT   1
`define IRQ_END_OF_FIELD_BIT    2
`define IRQ_PENDING_RESET       2'h0

`define COLOUR_ENCODING_LSB     0
`define COLOUR_BIT_WIDTH_LSB    8

`endif
